// ==== logic/srx_ctrl.sv ====
// Receive-side control: write pointer, single-receive timeout, activity scan, pin routing.
// Assumes all inputs are on sys_clk; the controller keeps its own ordering duties.
// What this block does
// R01: Receive pointer always shows address of the next byte to be stored.
// R02: Each stored payload byte advances the receive pointer by one.
// R03: Header accepted raises header event, implicit format included.
// R04: Single receive timeout runs absolutely from single receive entry.
// R05: Timeout equals programmed count times one symbol period.
// R06: On expiry set timeout flag and go to standby at once.
// R07: Controller clears timeout flag or sleeps before single receive again.
// R08: Controller programs timeout count between 4 and 1023 symbols.
// R09: Scan locks synthesizer first, then captures samples with receiver on.
// R10: After capture receiver and synthesizer off, then correlation begins.
// R11: Correlation finishes in slightly under one symbol period.
// R12: Capture lasts (2^SF + 32) / BW; rest is reduced-power processing.
// R13: Correlation end sets done flag; success sets found flag same cycle.
// R14: After reporting the scan result, return to standby.
// R15: Controller clears found flag before commanding receive.
// R16: Each of six pins has a two-bit mapping code.
// R17: Code 00 maps settled, found, scan done, hop, timeout, rx done.
// R18: Code 01 maps clock, lock, header, hop, hop, tx done.
// R19: Code 10 maps clock, lock, crc fail, hop, found, scan done; 11 none.
// R20: Each flag stays set until the controller writes one to it; a sleep request also clears the timeout flag.
`include "srx_cfg.svh"
module srx_ctrl
#(
    parameter int PTR_W = `SRX_PTR_W,
    parameter int TMO_W = `SRX_TMO_W
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Mode requests, one-cycle pulses
    input wire logic req_standby,
    input wire logic req_sleep,
    input wire logic req_rx_single,
    input wire logic req_rx_cont,
    input wire logic req_scan,
    // Configuration
    input wire logic [TMO_W-1:0] rx_window_symbols,
    input wire logic [3:0] spread_factor,
    input wire logic [15:0] sym_period_cyc,
    input wire logic [15:0] chip_period_cyc,
    input wire logic [PTR_W-1:0] rx_base_addr,
    input wire logic base_load,
    input wire logic [11:0] pin_route_reg_a,
    // Demodulator side
    input wire logic byte_stored,
    input wire logic header_accepted,
    input wire logic rx_packet_end,
    input wire logic crc_bad,
    input wire logic rx_tracking,
    input wire logic corr_done,
    input wire logic corr_hit,
    input wire logic hop_change,
    input wire logic tx_done,
    input wire logic pll_lock,
    input wire logic clock_src,
    // Flag clear, write-one bits
    input wire logic [`SRX_FLG_W-1:0] event_flag_clr,
    // Status
    output logic [PTR_W-1:0] rx_write_pointer_q,
    output logic [`SRX_FLG_W-1:0] event_flag_reg_q,
    output logic [2:0] mode_q,
    output logic rx_on_q,
    output logic synth_on_q,
    output logic corr_run_q,
    output logic [`SRX_PIN_N-1:0] event_pin_q
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    srx_pkg::srx_mode_t st_q;
    srx_pkg::srx_mode_t st_d;
    logic [TMO_W-1:0] sym_cnt_q;
    logic [TMO_W-1:0] sym_cnt_d;
    logic [`SRX_SYM_CNT_W-1:0] tick_q;
    logic [`SRX_SYM_CNT_W-1:0] tick_d;
    logic [23:0] phase_q;
    logic [23:0] phase_d;
    logic [PTR_W-1:0] ptr_d;
    logic [`SRX_FLG_W-1:0] set_v;
    logic [`SRX_FLG_W-1:0] flags;
    logic sym_tick;
    logic expired;
    logic cap_done;
    logic lock_done;
    logic corr_timeout;
    logic settled_q;
    logic [23:0] cap_len;
    logic [PTR_W-1:0] ptr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Symbol tick divider, one-cycle enable
    assign sym_tick = (tick_q >= sym_period_cyc - 16'h0001);
    assign tick_d = (st_q == srx_pkg::SRX_STANDBY || sym_tick) ? '0 : tick_q + 16'h0001;

    // Absolute count from entry; not stretched by signal activity
    assign expired = (st_q == srx_pkg::SRX_RX_SINGLE) && sym_tick
        && (sym_cnt_q + 10'h001 >= rx_window_symbols); // see R04, R05
    assign sym_cnt_d = (st_q != srx_pkg::SRX_RX_SINGLE) ? '0 :
        sym_tick ? sym_cnt_q + 10'h001 : sym_cnt_q; // see R05

    // Capture length in sys_clk cycles: (2^SF + 32) chips
    assign cap_len = ((24'h000001 << spread_factor) + 24'(`SRX_CAD_PAD)) * 24'(chip_period_cyc); // see R12
    assign lock_done = pll_lock && (phase_q >= 24'(`SRX_LOCK_CYC)); // see R09
    assign cap_done = (phase_q + 24'h000001 >= cap_len); // see R12
    // Guard: correlation never outlives a symbol even if the engine stalls
    assign corr_timeout = (phase_q + 24'h000002 >= 24'(sym_period_cyc)); // see R11

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencing
    always_comb
    begin
        st_d = st_q;
        phase_d = phase_q + 24'h000001;
        case (st_q)
            srx_pkg::SRX_STANDBY:
            begin
                phase_d = '0;
                // Request blocked while timeout flag pending
                if (req_rx_single && !flags[`SRX_FLG_TMO])
                    st_d = srx_pkg::SRX_RX_SINGLE; // see R07
                else if (req_rx_cont)
                    st_d = srx_pkg::SRX_RX_CONT;
                else if (req_scan)
                    st_d = srx_pkg::SRX_SCAN_LOCK;
            end
            srx_pkg::SRX_RX_SINGLE:
            begin
                if (expired || rx_packet_end || req_standby || req_sleep)
                    st_d = srx_pkg::SRX_STANDBY; // see R06
            end
            srx_pkg::SRX_RX_CONT:
            begin
                if (req_standby || req_sleep)
                    st_d = srx_pkg::SRX_STANDBY;
            end
            srx_pkg::SRX_SCAN_LOCK:
            begin
                if (lock_done)
                begin
                    st_d = srx_pkg::SRX_SCAN_CAPT; // see R09
                    phase_d = '0;
                end
            end
            srx_pkg::SRX_SCAN_CAPT:
            begin
                if (cap_done)
                begin
                    st_d = srx_pkg::SRX_SCAN_CORR; // see R10
                    phase_d = '0;
                end
            end
            srx_pkg::SRX_SCAN_CORR:
            begin
                if (corr_done || corr_timeout)
                    st_d = srx_pkg::SRX_SCAN_REPORT; // see R11
            end
            srx_pkg::SRX_SCAN_REPORT:
            begin
                st_d = srx_pkg::SRX_STANDBY; // see R14
            end
            default:
            begin
                st_d = srx_pkg::SRX_STANDBY;
            end
        endcase
        if (req_sleep)
            st_d = srx_pkg::SRX_STANDBY;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st_q <= srx_pkg::SRX_STANDBY;
            sym_cnt_q <= '0;
            tick_q <= '0;
            phase_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            sym_cnt_q <= sym_cnt_d;
            tick_q <= tick_d;
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive write pointer
    assign ptr_d = base_load ? rx_base_addr :
        (byte_stored && (st_q == srx_pkg::SRX_RX_SINGLE || st_q == srx_pkg::SRX_RX_CONT)) ?
        ptr_q + 8'h01 : ptr_q; // see R01, R02

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            ptr_q <= '0;
        else
            ptr_q <= ptr_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags
    logic rx_active;
    logic corr_end;
    assign rx_active = (st_q == srx_pkg::SRX_RX_SINGLE) || (st_q == srx_pkg::SRX_RX_CONT);
    assign corr_end = (st_q == srx_pkg::SRX_SCAN_CORR) && (corr_done || corr_timeout);

    always_comb
    begin
        set_v = '0;
        set_v[`SRX_FLG_RX_DONE] = rx_active && rx_packet_end;
        set_v[`SRX_FLG_HDR_OK] = rx_active && header_accepted; // see R03
        set_v[`SRX_FLG_TMO] = expired; // see R06
        set_v[`SRX_FLG_SCAN_DONE] = corr_end; // see R13
        set_v[`SRX_FLG_FOUND] = corr_end && corr_done && corr_hit; // see R13
        set_v[`SRX_FLG_CRC] = rx_active && rx_packet_end && crc_bad;
        set_v[`SRX_FLG_HOP] = hop_change;
        set_v[`SRX_FLG_TX_DONE] = tx_done;
    end

    genvar fi;
    generate
        for (fi = 0; fi < `SRX_FLG_W; fi++)
        begin : g_flag
            srx_flag u_flag
            (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .set_i(set_v[fi]),
                .clr_i(event_flag_clr[fi] | (req_sleep && fi == `SRX_FLG_TMO)),
                .flag_q(flags[fi])
            ); // see R20
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin routing
    srx_evt_if evt ();
    assign evt.mode_settled = settled_q;
    assign evt.activity_found_evt = flags[`SRX_FLG_FOUND];
    assign evt.activity_scan_finished_evt = flags[`SRX_FLG_SCAN_DONE];
    assign evt.hop_channel_change_evt = flags[`SRX_FLG_HOP];
    assign evt.rx_window_expired_evt = flags[`SRX_FLG_TMO];
    assign evt.rx_complete_evt = flags[`SRX_FLG_RX_DONE];
    assign evt.clock_out = clock_src;
    assign evt.synth_locked = pll_lock;
    assign evt.header_ok_evt = flags[`SRX_FLG_HDR_OK];
    assign evt.tx_complete_evt = flags[`SRX_FLG_TX_DONE];
    assign evt.payload_check_fail_evt = flags[`SRX_FLG_CRC];

    srx_pin_route u_route
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .evt(evt),
        .route_codes(pin_route_reg_a),
        .event_pin_q(event_pin_q)
    ); // see R16

    ////////////////////////////////////////////////////////////////////////////
    // Registered status outputs
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            settled_q <= 1'b0;
            rx_write_pointer_q <= '0;
            event_flag_reg_q <= '0;
            mode_q <= 3'h0;
            rx_on_q <= 1'b0;
            synth_on_q <= 1'b0;
            corr_run_q <= 1'b0;
        end
        else
        begin
            settled_q <= (st_d == st_q);
            rx_write_pointer_q <= ptr_d; // see R01
            event_flag_reg_q <= flags;
            mode_q <= st_d;
            rx_on_q <= (st_d == srx_pkg::SRX_SCAN_CAPT) || (st_d == srx_pkg::SRX_RX_SINGLE)
                || (st_d == srx_pkg::SRX_RX_CONT); // see R09
            synth_on_q <= (st_d != srx_pkg::SRX_STANDBY) && (st_d != srx_pkg::SRX_SCAN_CORR)
                && (st_d != srx_pkg::SRX_SCAN_REPORT); // see R10
            corr_run_q <= (st_d == srx_pkg::SRX_SCAN_CORR); // see R10
        end
    end
endmodule : srx_ctrl

// ==== logic/srx_flag.sv ====
// One sticky event flag: set by hardware, cleared by writing one.
// Assumes set and clear come from logic on sys_clk.
`include "srx_cfg.svh"
module srx_flag
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_q
);
    logic flag_d;
    // Set wins over a clear in the same cycle
    assign flag_d = set_i | (flag_q & ~clr_i); // see R20
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end
endmodule : srx_flag

// ==== logic/srx_pin_route.sv ====
// Routes modem events onto six event pins by two-bit codes.
// Assumes event inputs are sys_clk levels; outputs are registered.
`include "srx_cfg.svh"
module srx_pin_route
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Events and mapping
    srx_evt_if.dst evt,
    input wire logic [2*`SRX_PIN_N-1:0] route_codes,
    // Pins
    output logic [`SRX_PIN_N-1:0] event_pin_q
);
    logic [`SRX_PIN_N-1:0] code0;
    logic [`SRX_PIN_N-1:0] code1;
    logic [`SRX_PIN_N-1:0] code2;
    logic [`SRX_PIN_N-1:0] pin_d;
    assign code0 = {evt.mode_settled, evt.activity_found_evt, evt.activity_scan_finished_evt,
        evt.hop_channel_change_evt, evt.rx_window_expired_evt, evt.rx_complete_evt}; // see R17
    assign code1 = {evt.clock_out, evt.synth_locked, evt.header_ok_evt, evt.hop_channel_change_evt,
        evt.hop_channel_change_evt, evt.tx_complete_evt}; // see R18
    assign code2 = {evt.clock_out, evt.synth_locked, evt.payload_check_fail_evt, evt.hop_channel_change_evt,
        evt.activity_found_evt, evt.activity_scan_finished_evt}; // see R19
    genvar gi;
    generate
        for (gi = 0; gi < `SRX_PIN_N; gi++)
        begin : g_pin
            logic [1:0] code;
            assign code = route_codes[2*gi +: 2]; // see R16
            assign pin_d[gi] = (code == `SRX_ROUTE_EVT) ? code0[gi] :
                               (code == `SRX_ROUTE_HDR) ? code1[gi] :
                               (code == `SRX_ROUTE_CRC) ? code2[gi] : 1'b0; // see R19
        end
    endgenerate
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            event_pin_q <= '0;
        else
            event_pin_q <= pin_d;
    end
endmodule : srx_pin_route

// ==== pkg/srx_cfg.svh ====
// Timing counts, widths and code values for the receive-side control block.
// Assumes inclusion by bare name; definitions only.
`ifndef SRX_CFG_SVH
`define SRX_CFG_SVH
`define SRX_PTR_W 8
`define SRX_TMO_W 10
`define SRX_SYM_CNT_W 16
`define SRX_CAD_PAD 32
`define SRX_PIN_N 6
`define SRX_ROUTE_W 2
`define SRX_ROUTE_EVT 2'h0
`define SRX_ROUTE_HDR 2'h1
`define SRX_ROUTE_CRC 2'h2
`define SRX_FLG_RX_DONE 0
`define SRX_FLG_HDR_OK 1
`define SRX_FLG_TMO 2
`define SRX_FLG_SCAN_DONE 3
`define SRX_FLG_FOUND 4
`define SRX_FLG_CRC 5
`define SRX_FLG_HOP 6
`define SRX_FLG_TX_DONE 7
`define SRX_FLG_W 8
`define SRX_LOCK_CYC 16'h0010
`endif

// ==== pkg/srx_evt_if.sv ====
// Event bundle from the top module to the pin router.
// Assumes one clock domain.
interface srx_evt_if;
    logic mode_settled;
    logic activity_found_evt;
    logic activity_scan_finished_evt;
    logic hop_channel_change_evt;
    logic rx_window_expired_evt;
    logic rx_complete_evt;
    logic clock_out;
    logic synth_locked;
    logic header_ok_evt;
    logic tx_complete_evt;
    logic payload_check_fail_evt;
    modport src (output mode_settled, activity_found_evt, activity_scan_finished_evt, hop_channel_change_evt,
        rx_window_expired_evt, rx_complete_evt, clock_out, synth_locked, header_ok_evt, tx_complete_evt,
        payload_check_fail_evt);
    modport dst (input mode_settled, activity_found_evt, activity_scan_finished_evt, hop_channel_change_evt,
        rx_window_expired_evt, rx_complete_evt, clock_out, synth_locked, header_ok_evt, tx_complete_evt,
        payload_check_fail_evt);
endinterface : srx_evt_if

// ==== pkg/srx_pkg.sv ====
// Types shared by the receive-side control block.
// Assumes srx_cfg.svh is compiled alongside.
package srx_pkg;
    typedef enum logic [2:0]
    {
        SRX_STANDBY = 3'h0,
        SRX_RX_SINGLE = 3'h1,
        SRX_RX_CONT = 3'h3,
        SRX_SCAN_LOCK = 3'h2,
        SRX_SCAN_CAPT = 3'h6,
        SRX_SCAN_CORR = 3'h7,
        SRX_SCAN_REPORT = 3'h5
    } srx_mode_t;
endpackage : srx_pkg

// ==== sim/srx_ctrl_checker.sv ====
// Assertions on the receive-side control block.
// Assumes binding to srx_ctrl; watches its ports only.
module srx_ctrl_checker
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Inputs
    input wire logic req_standby, req_sleep, req_rx_single, req_rx_cont, req_scan,
    input wire logic rx_packet_end, byte_stored, base_load, corr_done,
    input wire logic [7:0] rx_base_addr, event_flag_clr,
    input wire logic [9:0] rx_window_symbols,
    input wire logic [15:0] sym_period_cyc, chip_period_cyc,
    input wire logic [3:0] spread_factor,
    input wire logic [11:0] pin_route_reg_a,
    // Outputs
    input wire logic [7:0] rx_write_pointer_q, event_flag_reg_q,
    input wire logic [2:0] mode_q,
    input wire logic rx_on_q, synth_on_q, corr_run_q,
    input wire logic [5:0] event_pin_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [31:0] tm_q, cap_q, cr_q;
    logic [11:0] codes_q;
    wire [7:0] f = event_flag_reg_q;
    wire [25:0] tmo_len = rx_window_symbols * sym_period_cyc;
    wire [31:0] cap_len = ((32'h1 << spread_factor) + 32'h20) * chip_period_cyc;
    wire [3:0] pexp = codes_q == 12'h000 ? {f[3], f[6], f[2], f[0]} : codes_q == 12'h555 ? {f[1], f[6], f[6], f[7]} :
        codes_q == 12'hAAA ? {f[5], f[6], f[4], f[3]} : 4'h0;
    ////////////////////////////////////////////////////////////////////////
    // Dwell counters; lengths are judged on the cycle after each phase
    always_ff @(posedge sys_clk)
    begin
        tm_q <= (mode_q == 3'h1) ? tm_q + 32'h1 : 32'h0;
        cap_q <= (mode_q == 3'h6) ? cap_q + 32'h1 : 32'h0;
        cr_q <= (mode_q == 3'h7) ? cr_q + 32'h1 : 32'h0;
        codes_q <= pin_route_reg_a;
    end
    ////////////////////////////////////////////////////////////////////////
    ptr_step_a: assert property ((mode_q == 3'h1 || mode_q == 3'h3) && byte_stored && !base_load
        |=> rx_write_pointer_q == $past(rx_write_pointer_q) + 8'h01) else $error("pointer did not advance");
    ptr_load_a: assert property (base_load |=> rx_write_pointer_q == $past(rx_base_addr))
        else $error("pointer not loaded");
    single_entry_a: assert property (mode_q == 3'h0 && req_rx_single && !f[2] && !req_sleep && !req_standby
        && !req_scan && !req_rx_cont |=> mode_q == 3'h1 && rx_on_q) else $error("single receive not entered");
    tmo_time_a: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h1 && !$past(req_standby)
        && !$past(req_sleep) && !$past(rx_packet_end) |-> $past(tm_q) + 32'h1 >= tmo_len && $past(tm_q) <= tmo_len)
        else $error("timeout length wrong");
    tmo_flag_a: assert property ($rose(f[2]) |-> $past(mode_q) == 3'h0 && $past(mode_q, 2) == 3'h1)
        else $error("timeout flag without leaving single receive");
    capt_on_a: assert property ($rose(mode_q == 3'h6) |-> $past(mode_q) == 3'h2 && rx_on_q && synth_on_q)
        else $error("capture not after lock");
    corr_off_a: assert property (mode_q == 3'h7 |-> !rx_on_q && !synth_on_q && corr_run_q
        && ($past(mode_q) == 3'h6 || $past(mode_q) == 3'h7)) else $error("correlation with receiver on");
    capt_len_a: assert property (mode_q != 3'h6 && $past(mode_q) == 3'h6
        |-> $past(cap_q) + 32'h1 == $past(cap_len)) else $error("capture length wrong");
    corr_len_a: assert property (mode_q != 3'h7 && $past(mode_q) == 3'h7
        |-> $past(cr_q) + 32'h1 < {16'h0, $past(sym_period_cyc)}) else $error("correlation too long");
    scan_report_a: assert property (mode_q == 3'h5 |=> mode_q == 3'h0 && f[3])
        else $error("scan report wrong");
    found_pair_a: assert property ($rose(f[4]) |-> $rose(f[3])) else $error("found flag alone");
    flag_hold_a: assert property (($past(f) & ~f & ~$past(event_flag_clr, 2) & 8'hFB) == 8'h00)
        else $error("flag dropped without clear");
    pin_route_a: assert property (codes_q inside {12'h000, 12'h555, 12'hAAA, 12'hFFF}
        |-> event_pin_q[3:0] == pexp) else $error("pin routing wrong");
endmodule : srx_ctrl_checker

bind srx_ctrl srx_ctrl_checker chk_i (.*);

// ==== sim/srx_ctrl_tb.sv ====
// Self-checking bench for the receive-side control block.
// Assumes srx_ctrl, its checker and the demodulator model are compiled first.
module srx_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] req = 5'h00;
    logic [4:0] dm = 5'h00;
    logic [9:0] n_sym = 10'h004;
    logic [3:0] sf = 4'h6;
    logic [15:0] sym_p = 16'h0020;
    logic [15:0] chip_p = 16'h0001;
    logic [7:0] base = 8'h00;
    logic bl = 1'b0;
    logic [11:0] route = 12'h000;
    logic crc = 1'b0;
    logic hit = 1'b0;
    logic [7:0] lat = 8'h00;
    logic [7:0] clr = 8'h00;
    logic pll_lock, corr_done, corr_hit, rx_on, syn_on, corr_run;
    logic [7:0] ptr, flags, prevf, ep;
    logic [7:0] expf = 8'h00;
    logic [2:0] mode;
    logic [5:0] pins;
    logic [7:0] notes[$];
    int n_fail = 0;
    int check_count = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    srx_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .req_standby(req[0]), .req_sleep(req[1]), .req_rx_single(req[2]),
        .req_rx_cont(req[3]), .req_scan(req[4]), .rx_window_symbols(n_sym), .spread_factor(sf), .sym_period_cyc(sym_p),
        .chip_period_cyc(chip_p), .rx_base_addr(base), .base_load(bl), .pin_route_reg_a(route), .byte_stored(dm[0]),
        .header_accepted(dm[1]), .rx_packet_end(dm[2]), .crc_bad(crc), .rx_tracking(1'b0), .corr_done(corr_done),
        .corr_hit(corr_hit), .hop_change(dm[3]), .tx_done(dm[4]), .pll_lock(pll_lock), .clock_src(1'b0),
        .event_flag_clr(clr), .rx_write_pointer_q(ptr), .event_flag_reg_q(flags), .mode_q(mode), .rx_on_q(rx_on),
        .synth_on_q(syn_on), .corr_run_q(corr_run), .event_pin_q(pins));
    srx_demod_model far (.sys_clk(sys_clk), .synth_on_q(syn_on), .corr_run_q(corr_run), .hit(hit), .lat(lat),
        .pll_lock(pll_lock), .corr_done(corr_done), .corr_hit(corr_hit));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick
    // Each pulse waits an edge first so back-to-back calls never collide
    task req_p(input logic [4:0] r);
        tick(1);
        req = r;
        tick(1);
        req = 5'h00;
    endtask : req_p
    task dm_p(input logic [4:0] r);
        tick(1);
        dm = r;
        tick(1);
        dm = 5'h00;
    endtask : dm_p
    task clr_f;
        tick(1);
        clr = 8'hFF;
        tick(1);
        clr = 8'h00;
        expf = 8'h00;
        tick(2);
    endtask : clr_f
    task wait_bit(input int b);
        int k;
        k = 0;
        while (flags[b] !== 1'b1 && k < 3000)
        begin
            tick(1);
            k++;
        end
        chk(flags[b], 1'b1);
    endtask : wait_bit
    function automatic logic [3:0] pin_exp(input logic [1:0] c, input logic [7:0] f);
        return c == 2'h0 ? {f[3], f[6], f[2], f[0]} : c == 2'h1 ? {f[1], f[6], f[6], f[7]} :
            c == 2'h2 ? {f[5], f[6], f[4], f[3]} : 4'h0;
    endfunction : pin_exp
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////
    // Each cycle with any rising flag takes the oldest note
    always @(posedge sys_clk)
    begin
        if (rst_b && (flags & ~prevf) != 8'h00)
        begin
            if (notes.size() > 0)
                chk(flags, notes.pop_front());
            else
                chk(flags, 8'h00);
        end
        prevf = flags;
    end
    initial
    begin
        #200000;
        n_fail++;
        complete_run;
    end
    initial
    begin
        n = $urandom(43792);
        tick(12);
        rst_b = 1'b1;
        tick(1);
        base = 8'($urandom);
        bl = 1'b1;
        tick(1);
        bl = 1'b0;
        chk(ptr, base);
        dm = 5'h01;
        tick(3);
        dm = 5'h00;
        chk(ptr, base);
        req_p(5'h08);
        n = $urandom_range(1, 300);
        ep = base + n[7:0];
        dm = 5'h01;
        tick(n);
        dm = 5'h00;
        chk(ptr, ep);
        for (int j = 1; j < 5; j++)
        begin
            crc = 1'($urandom);
            expf = expf | (j == 1 ? 8'h02 : j == 2 ? {2'h0, crc, 5'h01} : j == 3 ? 8'h40 : 8'h80);
            notes.push_back(expf);
            dm_p(5'h01 << j);
            tick(3);
        end
        req_p(5'h01);
        for (int c = 0; c < 4; c++)
        begin
            route = {6{c[1:0]}};
            tick(2);
            chk(pins[3:0], pin_exp(c[1:0], expf));
            // Upper pins: settled standby under code 00; clock and lock idle low under 01 and 10, none under 11
            chk(pins[5:4], {c == 0, 1'b0});
        end
        route = 12'h000;
        clr_f;
        $display("pointer and routing test done");
        for (int r = 0; r < 2; r++)
        begin
            n_sym = 10'($urandom_range(4, 12));
            sym_p = 16'($urandom_range(2, 8));
            req_p(5'h04);
            chk(mode, 3'h1);
            if (r == 1)
            begin
                expf = 8'h02;
                notes.push_back(expf);
                dm_p(5'h02);
            end
            expf = expf | 8'h04;
            notes.push_back(expf);
            wait_bit(2);
            tick(1);
            chk(mode, 3'h0);
            chk(pins[1], 1'b1);
            req_p(5'h04);
            chk(mode, 3'h0);
            if (r == 0)
            begin
                req_p(5'h02);
                tick(1);
                chk(flags[2], 1'b0);
            end
            clr_f;
        end
        $display("timeout test done");
        for (int i = 0; i < 4; i++)
        begin
            sf = 4'($urandom_range(5, 7));
            chip_p = 16'($urandom_range(1, 2));
            sym_p = 16'h0020;
            hit = i[0];
            lat = i > 1 ? 8'hFF : 8'($urandom_range(0, 20));
            expf = (hit && i < 2) ? 8'h18 : 8'h08;
            notes.push_back(expf);
            req_p(5'h10);
            chk(mode, 3'h2);
            wait_bit(3);
            tick(1);
            chk(mode, 3'h0);
            chk(flags[4], expf[4]);
            clr_f;
        end
        $display("scan test done");
        // Mid-run reset from standby: mode, pointer and flags return to zero
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(1);
        chk(mode, 3'h0);
        chk(ptr, 8'h00);
        chk(flags, 8'h00);
        $display("reset test done");
        complete_run;
    end
endmodule : srx_ctrl_tb

// ==== sim/srx_demod_model.sv ====
// Demodulator and synthesizer stand-in on the far side of the control block.
// Assumes the same sys_clk; answers with a latency set by the bench.
module srx_demod_model
(
    input wire logic sys_clk,
    input wire logic synth_on_q,
    input wire logic corr_run_q,
    input wire logic hit,
    input wire logic [7:0] lat,
    output logic pll_lock,
    output logic corr_done,
    output logic corr_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    logic [2:0] lk = 3'h0;
    initial
    begin
        pll_lock = 1'b0;
        corr_done = 1'b0;
        corr_hit = 1'b0;
    end
    // A large latency leaves the engine silent, forcing the timed end
    always @(posedge sys_clk)
    begin
        lk <= synth_on_q ? lk + 3'(lk != 3'h7) : 3'h0;
        pll_lock <= synth_on_q && lk >= 3'h3;
        cnt <= corr_run_q ? cnt + 8'h01 : 8'h00;
        corr_done <= corr_run_q && cnt == lat;
        corr_hit <= (corr_run_q && cnt == lat) ? hit : ~corr_hit;
    end
endmodule : srx_demod_model
